// ### rtl/buck_regs_pkg.sv
// Shared constants for the regulator control register bank
package buck_regs_pkg;

	// Register offsets
	localparam logic [7:0] REG_FAULT  = 8'h00;
	localparam logic [7:0] REG_LEVEL  = 8'h01;
	localparam logic [7:0] REG_OPTION = 8'h02;
	localparam logic [7:0] REG_IDENT  = 8'h03;
	localparam logic [7:0] REG_RAMP   = 8'h04;

	// Fixed upper bits of the 7-bit slave address
	localparam logic [4:0] DEV_ADDR_HI = 5'h18;

	// Field positions
	localparam int FLT_UV_BIT     = 0;
	localparam int FLT_OT_BIT     = 1;
	localparam int FLT_OC_BIT     = 2;
	localparam int LVL_EN_BIT     = 7;
	localparam int OPT_MODE_BIT   = 0;
	localparam int OPT_EDGE_BIT   = 3;
	localparam int OPT_BYPASS_BIT = 4;
	localparam int RMP_GOOD_BIT   = 3;
	localparam int RMP_DISCH_BIT  = 4;
	localparam int RMP_GO_BIT     = 5;

	// Reset values and fixed read-back patterns
	localparam logic       ENABLE_RST   = 1'h1;
	localparam logic       EDGE_RST     = 1'h1;
	localparam logic       MODE_RST     = 1'h1;
	localparam logic       BYPASS_RST   = 1'h0;
	localparam logic       DISCH_RST    = 1'h0;
	localparam logic       GO_RST       = 1'h0;
	localparam logic [2:0] REFERENCE_RAMP_RATE_RST     = 3'h3;
	localparam logic [2:0] REFERENCE_RAMP_RATE_MIN     = 3'h2;
	localparam logic [7:0] OPTION_FIXED = 8'h26;

	// Timing
	localparam int CLK_FREQ_KHZ    = 100000;
	localparam int POWER_GOOD_PIN_DELAY_MS  = 45;
	localparam int POWER_GOOD_PIN_DELAY_CYC = POWER_GOOD_PIN_DELAY_MS * CLK_FREQ_KHZ;
	localparam int RAMP_GUARD_CYC  = 4;

	// Bit counter marks within one byte slot
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_ACK  = 4'h8;

	// Serial engine states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ADDR  = 3'b001,
		ST_REG   = 3'b010,
		ST_WDATA = 3'b011,
		ST_RDATA = 3'b100,
		ST_WAIT  = 3'b101
	} link_state_t;

endpackage

// ### rtl/buck_regs.sv
// Two-wire slave and control/status register bank of a step-down regulator
//
// What this block does
// - Over-current latches status bit 2, W1C
// - Over-temperature latches status bit 1, W1C
// - Feedback undervoltage latches status bit 0, W1C
// - Register 1: enable bit 7, code 6:0
// - Startup level code comes from variant strap
// - Option bit 4 bypasses power-good delay
// - Option bit 3 selects switch edge speed
// - Option bit 0 forces continuous PWM mode
// - Register 3 read-only, maker code high
// - Identification bits 3:2 report address variant
// - Identification bits 1:0 report default output choice
// - Any ramp register write starts transition
// - After startup ramp to default code
// - Ramp bit 4 discharges output when disabled
// - Ramp bit 3 shows settled regulation
// - Ramp bits 2:0 select reference_ramp_rate, default 011
// - Defaults loaded before any bus access
// - Answer only own address, LSB is direction
// - Write data committed only at stop
// - Bus and registers work while disabled
`timescale 1ns/10ps

module buck_regs
	import buck_regs_pkg::*;
#(
	parameter int         POWER_GOOD_PIN_DELAY = POWER_GOOD_PIN_DELAY_CYC, // Cycles of power-good delay
	parameter logic [3:0] MAKER_CODE  = 4'h5             // Value arbitrary
) (
	// Clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       rstn_i,
	// Two-wire bus pins
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output logic            sda_o,
	output logic            sda_oe_o,
	// Analog status inputs
	input  wire logic       overcurrent_i,
	input  wire logic       overtemp_i,
	input  wire logic       feedback_undervoltage_i,
	input  wire logic       in_regulation_i,
	input  wire logic       reference_settled_i,
	// Variant straps
	input  wire logic [1:0] bus_id_variant_i,
	input  wire logic [1:0] default_output_choice_i,
	input  wire logic [6:0] default_level_code_i,
	// Regulator controls
	output logic            regulator_enable_o,
	output logic [6:0]      level_code_o,
	output logic            power_ok_delay_bypass_o,
	output logic            switch_edge_speed_o,
	output logic            light_load_skip_o,
	output logic            discharge_o,
	output logic            ramp_start_o,
	output logic [2:0]      reference_ramp_rate_o,
	output logic            power_good_pin_o
);

	// Refuse a delay that the counter cannot hold
	if (POWER_GOOD_PIN_DELAY < 1 || POWER_GOOD_PIN_DELAY > 16777215) begin : g_bad_delay
		$error("power-good delay out of range");
	end

	localparam int NSYNC = 18;                   // Width of the pin synchroniser

	logic [NSYNC-1:0] sync_a;                    // First stage, read only by second
	logic [NSYNC-1:0] sync_b;                    // Second stage, safe to use
	logic             scl_s, sda_s;              // Synchronised bus lines
	logic             scl_d, sda_d;              // Previous samples for edges
	logic             oc_s, ot_s, uv_s;          // Synchronised fault levels
	logic             inreg_s, settled_s;        // Synchronised regulation status
	logic [1:0]       variant_s, choice_s;       // Synchronised straps
	logic [6:0]       code_s;                    // Synchronised default code
	logic             scl_rise, scl_fall;        // Clock edges on the bus
	logic             start_det, stop_det;       // Bus conditions
	link_state_t      state;                     // Serial engine state
	logic [3:0]       bit_cnt;                   // Bits seen in current slot
	logic [7:0]       shift;                     // Receive or transmit byte
	logic [7:0]       ptr;                       // Selected register
	logic [7:0]       wr_data;                   // Data held until stop
	logic             wr_pending;                // A write waits for stop
	logic             ack_now;                   // Drive ack in next slot
	logic             commit;                    // Stop ends a pending write
	logic [7:0]       rx_byte;                   // Byte completed at this rise
	logic [7:0]       rd_data;                   // Read mux output
	logic [2:0]       fault;                     // Latched fault flags
	logic [2:0]       fault_clr;                 // W1C mask from a commit
	logic [1:0]       id_variant;                // Captured address variant
	logic [1:0]       id_choice;                 // Captured default output choice
	logic             go_bit;                    // Last value written to trigger
	logic             discharge_en;              // Discharge option
	logic             boot_done;                 // Startup ramp issued
	logic [2:0]       guard_cnt;                 // Hides good right after a ramp
	logic             regulation_good;           // Settled regulation status
	logic [23:0]      pg_cnt;                    // Power-good delay counter

	// True for offsets that hold a register
	function automatic logic map_hit(input logic [7:0] a);
		map_hit = (a <= REG_RAMP);
	endfunction

	// Pins cross into the clock domain through two flip-flops
	// No reset here: the straps must already be valid while reset is held
	always_ff @(posedge clk_sys_i) begin
		sync_a <= {scl_i, sda_i, overcurrent_i, overtemp_i, feedback_undervoltage_i, in_regulation_i,
			reference_settled_i, bus_id_variant_i, default_output_choice_i, default_level_code_i};
		sync_b <= sync_a;
	end

	assign {scl_s, sda_s, oc_s, ot_s, uv_s, inreg_s, settled_s, variant_s, choice_s, code_s} = sync_b;

	// Previous line levels for edge finding
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			// Idle bus level, so no false edge or stop follows reset
			scl_d <= 1'b1;
			sda_d <= 1'b1;
		end else begin
			scl_d <= scl_s;
			sda_d <= sda_s;
		end
	end

	// Bus events; start and stop need clock high on both samples
	assign scl_rise  = scl_s & ~scl_d;
	assign scl_fall  = ~scl_s & scl_d;
	assign start_det = scl_s & scl_d & sda_d & ~sda_s;
	assign stop_det  = scl_s & scl_d & ~sda_d & sda_s;
	assign rx_byte   = {shift[6:0], sda_s};
	assign commit    = stop_det & wr_pending;

	// Serial engine: byte framing, acknowledge and read shifting
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			state      <= ST_IDLE;
			bit_cnt    <= '0;
			shift      <= '0;
			ptr        <= REG_FAULT;
			wr_data    <= '0;
			wr_pending <= 1'b0;
			ack_now    <= 1'b0;
			sda_oe_o   <= 1'b0;
		end else if (start_det) begin
			// Repeated start drops a write that never saw its stop
			state      <= ST_ADDR;
			bit_cnt    <= '0;
			wr_pending <= 1'b0;
			sda_oe_o   <= 1'b0;
		end else if (stop_det) begin
			state      <= ST_IDLE;
			wr_pending <= 1'b0;
			sda_oe_o   <= 1'b0;
		end else if (scl_rise && state != ST_IDLE) begin
			if (bit_cnt != BIT_ACK) begin
				// Transmit byte must not be overwritten by the line
				if (state != ST_RDATA) begin
					shift <= rx_byte;
				end
				bit_cnt <= bit_cnt + 4'h1;
				if (bit_cnt == BIT_LAST) begin
					unique case (state)
						ST_ADDR: begin
							ack_now <= (rx_byte[7:1] == {DEV_ADDR_HI, id_variant});
						end
						ST_REG: begin
							ack_now <= map_hit(rx_byte);
							ptr     <= rx_byte;
						end
						// Only the first data byte is taken
						ST_WDATA: begin
							ack_now    <= 1'b1;
							wr_data    <= rx_byte;
							wr_pending <= 1'b1;
						end
						ST_IDLE, ST_RDATA, ST_WAIT: begin
							ack_now <= 1'b0;
						end
					endcase
				end
			end else begin
				// Ninth rise: move to the next byte
				bit_cnt <= '0;
				unique case (state)
					ST_ADDR: begin
						if (!ack_now) begin
							state <= ST_WAIT;
						end else if (shift[0]) begin
							state <= ST_RDATA;
							shift <= rd_data;
						end else begin
							state <= ST_REG;
						end
					end
					ST_REG: begin
						state <= ack_now ? ST_WDATA : ST_WAIT;
					end
					ST_RDATA: begin
						// Master ack asks for another copy, nack ends
						if (sda_s) begin
							state <= ST_WAIT;
						end else begin
							shift <= rd_data;
						end
					end
					ST_IDLE, ST_WDATA, ST_WAIT: begin
						state <= ST_WAIT;
					end
				endcase
			end
		end else if (scl_fall) begin
			// Drive changes only while the clock is low and is held across the high phase
			if (bit_cnt == BIT_ACK) begin
				sda_oe_o <= ack_now;
			end else if (state == ST_RDATA) begin
				sda_oe_o <= ~shift[3'(BIT_LAST - bit_cnt)];
			end else begin
				sda_oe_o <= 1'b0;
			end
		end
	end

	// Open-drain line is only ever pulled low
	always_ff @(posedge clk_sys_i) begin
		sda_o <= 1'b0;
	end

	// Read mux, reserved bits fixed
	always_comb begin
		rd_data = 8'h00;
		if (map_hit(ptr)) begin
			unique case (ptr[2:0])
				3'h0: rd_data = {5'h00, fault};
				3'h1: rd_data = {regulator_enable_o, level_code_o};
				3'h2: rd_data = OPTION_FIXED | {3'h0, power_ok_delay_bypass_o, switch_edge_speed_o, 2'h0,
					~light_load_skip_o};
				3'h3: rd_data = {MAKER_CODE, id_variant, id_choice};
				3'h4: rd_data = {2'h0, go_bit, discharge_en, regulation_good, reference_ramp_rate_o};
				default: rd_data = 8'h00;
			endcase
		end
	end

	// Strap capture during reset; reset must span the synchroniser
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			id_variant <= variant_s;
			id_choice  <= choice_s;
		end
	end

	// Fault flags, set wins over a clear in the same cycle
	assign fault_clr = (commit && ptr == REG_FAULT) ? wr_data[2:0] : 3'h0;

	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			fault <= '0;
		end else begin
			fault[FLT_OC_BIT] <= (fault[FLT_OC_BIT] & ~fault_clr[FLT_OC_BIT]) | oc_s;
			fault[FLT_OT_BIT] <= (fault[FLT_OT_BIT] & ~fault_clr[FLT_OT_BIT]) | ot_s;
			fault[FLT_UV_BIT] <= (fault[FLT_UV_BIT] & ~fault_clr[FLT_UV_BIT]) | uv_s;
		end
	end

	// Enable and level code register
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			regulator_enable_o <= ENABLE_RST;
			level_code_o       <= code_s;
		end else if (commit && ptr == REG_LEVEL) begin
			regulator_enable_o <= wr_data[LVL_EN_BIT];
			level_code_o       <= wr_data[6:0];
		end
	end

	// Option register; reserved bits are not stored at all
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			power_ok_delay_bypass_o <= BYPASS_RST;
			switch_edge_speed_o     <= EDGE_RST;
			light_load_skip_o       <= ~MODE_RST;
		end else if (commit && ptr == REG_OPTION) begin
			power_ok_delay_bypass_o <= wr_data[OPT_BYPASS_BIT];
			switch_edge_speed_o     <= wr_data[OPT_EDGE_BIT];
			light_load_skip_o       <= ~wr_data[OPT_MODE_BIT];
		end
	end

	// Ramp register writable fields
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			go_bit                <= GO_RST;
			discharge_en          <= DISCH_RST;
			reference_ramp_rate_o <= REFERENCE_RAMP_RATE_RST;
		end else if (commit && ptr == REG_RAMP) begin
			go_bit       <= wr_data[RMP_GO_BIT];
			discharge_en <= wr_data[RMP_DISCH_BIT];
			if (wr_data[2:0] >= REFERENCE_RAMP_RATE_MIN) begin
				reference_ramp_rate_o <= wr_data[2:0];
			end
		end
	end

	// Ramp trigger pulse and discharge control
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			boot_done    <= 1'b0;
			ramp_start_o <= 1'b0;
			discharge_o  <= 1'b0;
		end else begin
			boot_done    <= 1'b1;
			ramp_start_o <= ~boot_done | (commit && ptr == REG_RAMP);
			discharge_o  <= discharge_en & ~regulator_enable_o;
		end
	end

	// Regulation good; guard covers the analog side's sync latency
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			guard_cnt       <= 3'(RAMP_GUARD_CYC);
			regulation_good <= 1'b0;
		end else begin
			if (ramp_start_o) begin
				guard_cnt <= 3'(RAMP_GUARD_CYC);
			end else if (guard_cnt != 3'h0) begin
				guard_cnt <= guard_cnt - 3'h1;
			end
			regulation_good <= inreg_s & settled_s & (guard_cnt == 3'h0) & ~ramp_start_o;
		end
	end

	// Power-good pin with optional delay
	always_ff @(posedge clk_sys_i) begin
		if (!rstn_i) begin
			pg_cnt           <= '0;
			power_good_pin_o <= 1'b0;
		end else begin
			if (!regulation_good) begin
				pg_cnt <= '0;
			end else if (pg_cnt != 24'(POWER_GOOD_PIN_DELAY)) begin
				pg_cnt <= pg_cnt + 24'h1;
			end
			power_good_pin_o <= regulation_good & (power_ok_delay_bypass_o | pg_cnt == 24'(POWER_GOOD_PIN_DELAY));
		end
	end

	// Checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);

	oc_latch_a: assert property (oc_s |=> fault[FLT_OC_BIT]) else $error("over-current not latched");
	ot_latch_a: assert property (ot_s |=> fault[FLT_OT_BIT]) else $error("over-temp not latched");
	uv_hold_a: assert property (fault[FLT_UV_BIT] && !fault_clr[FLT_UV_BIT] |=> fault[FLT_UV_BIT])
		else $error("undervoltage flag lost");
	level_commit_a: assert property ($changed(level_code_o) |-> $past(stop_det))
		else $error("level changed without stop");
	addr_ack_a: assert property (state == ST_ADDR && scl_fall && bit_cnt == BIT_ACK
		&& shift[7:1] != {DEV_ADDR_HI, id_variant} |=> !sda_oe_o) else $error("foreign address acked");
	go_pulse_a: assert property (commit && ptr == REG_RAMP |=> ramp_start_o ##1 !ramp_start_o)
		else $error("ramp write gave no pulse");
	good_ramp_a: assert property (ramp_start_o |=> !regulation_good [*4])
		else $error("good during transition");
	disch_gate_a: assert property (regulator_enable_o |=> !discharge_o)
		else $error("discharge while enabled");
	reference_ramp_rate_legal_a: assert property (reference_ramp_rate_o >= REFERENCE_RAMP_RATE_MIN) else $error("reserved reference_ramp_rate code");
	pg_delay_a: assert property ($rose(power_good_pin_o) && !power_ok_delay_bypass_o
		|-> $past(pg_cnt) == 24'(POWER_GOOD_PIN_DELAY)) else $error("power-good early");

	write_cv: cover property (commit && ptr == REG_LEVEL);
	read_cv: cover property (state == ST_RDATA && scl_fall);
	clear_cv: cover property (commit && ptr == REG_FAULT && fault != 3'h0);

endmodule

// ### tb/i2c_host_model.sv
// Two-wire bus master model that paces frames toward the register bank
`timescale 1ns/10ps

module i2c_host_model (
	// Pacing clock
	input  wire logic clk_sys_i,
	// Resolved data line
	input  wire logic sda_i,
	// Bus clock and data pull-down
	output logic      scl_o,
	output logic      pull_o
);
	int stall = 0; // Extra low cycles per byte, a slow master

	// Idle bus: both lines released high, clock stands still
	initial begin
		scl_o = 1'b1;
		pull_o = 1'b0;
	end

	// Waits whole cycles; every change lands at a falling edge
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask

	// Data moves mid-low, well after the device drops its ack
	task automatic slot(input logic p, output logic g);
		tick(4);
		pull_o = p;
		tick(4);
		scl_o = 1'b1;
		tick(4);
		g = sda_i;
		tick(4);
		scl_o = 1'b0;
	endtask

	// Start or restart: data falls with clock high
	task automatic start();
		tick(4);
		pull_o = 1'b0;
		tick(4);
		scl_o = 1'b1;
		tick(4);
		pull_o = 1'b1;
		tick(4);
		scl_o = 1'b0;
	endtask

	// Stop: data rises with clock high, then room for the commit
	task automatic stop();
		tick(4);
		pull_o = 1'b1;
		tick(4);
		scl_o = 1'b1;
		tick(4);
		pull_o = 1'b0;
		tick(12);
	endtask

	// Byte out MSB first; a low line in slot nine is an ack
	task automatic send(input logic [7:0] b, output logic ack);
		logic g;
		for (int i = 7; i >= 0; i--)
			slot(~b[i], g);
		slot(1'b0, g);
		ack = ~g;
		tick(stall);
	endtask

	// Byte in; the last byte of a read is not acknowledged
	task automatic recv(input logic last, output logic [7:0] d);
		logic g;
		for (int i = 7; i >= 0; i--)
			slot(1'b0, d[i]);
		slot(~last, g);
		tick(stall);
	endtask
endmodule

// ### tb/tb_top.sv
// Self-checking bench of the regulator register bank
`timescale 1ns/10ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin num_errors++; \
	$display("unexpected at %0t: got %h expected %h", $time, a, e); end end

module tb_top
	import buck_regs_pkg::*;
;
	localparam int         PG_DLY = 50;    // Short power-good delay
	localparam logic [3:0] MAKER  = 4'hA;  // Value arbitrary
	localparam logic [1:0] VAR    = 2'h2;  // Bus address variant
	localparam logic [6:0] DEV    = {DEV_ADDR_HI, VAR};
	// Clock, reset and bus wires
	logic        clk_sys_i = 1'b0;
	logic        rstn_i;
	logic        scl;
	logic        pull;
	logic        sda;
	// Fault levels by status bit, regulation inputs, straps
	logic [2:0]  fault;
	logic        in_reg;
	logic        settled;
	logic [1:0]  choice;
	logic [6:0]  lvl;
	// Design outputs
	logic        sda_o;
	logic        sda_oe;
	logic        en;
	logic [6:0]  level;
	logic        bypass;
	logic        edge_spd;
	logic        skip;
	logic        disch;
	logic        ramp;
	logic [2:0]  rate;
	logic        pg;
	// Bench state
	int          num_errors = 0;
	int          compares   = 0;
	int          ramp_cnt   = 0;
	logic [31:0] seed       = 32'h2B14A809;
	logic [7:0]  exp_q[$];
	logic [7:0]  seen;
	event        seen_ev;
	logic [7:0]  d;
	logic [7:0]  v;
	logic [7:0]  idv;
	logic [7:0]  dflt[5];
	logic [2:0]  acks;
	logic        a;

	// Open drain with pull-up: low while either side pulls
	assign sda = ~pull & (sda_oe ? sda_o : 1'b1);

	always #5 clk_sys_i = ~clk_sys_i;

	// Counts startup and write-triggered ramps
	always @(posedge clk_sys_i)
		if (ramp === 1'b1)
			ramp_cnt++;

	buck_regs #(.POWER_GOOD_PIN_DELAY(PG_DLY), .MAKER_CODE(MAKER)) dut (
		.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe_o(sda_oe),
		.overcurrent_i(fault[2]), .overtemp_i(fault[1]), .feedback_undervoltage_i(fault[0]),
		.in_regulation_i(in_reg), .reference_settled_i(settled), .bus_id_variant_i(VAR),
		.default_output_choice_i(choice), .default_level_code_i(lvl), .regulator_enable_o(en),
		.level_code_o(level), .power_ok_delay_bypass_o(bypass), .switch_edge_speed_o(edge_spd),
		.light_load_skip_o(skip), .discharge_o(disch), .ramp_start_o(ramp), .reference_ramp_rate_o(rate),
		.power_good_pin_o(pg));

	i2c_host_model host (.clk_sys_i(clk_sys_i), .sda_i(sda), .scl_o(scl), .pull_o(pull));

	function automatic logic [31:0] xs(input logic [31:0] s);
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction

	// Notes the expectation, then shows the result to the watcher
	task automatic note(input logic [7:0] e, input logic [7:0] act);
		exp_q.push_back(e);
		seen = act;
		-> seen_ev;
		// Lets the watcher compare without moving stimulus off the falling edge
		#0;
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask

	task automatic wr(input logic [7:0] r, input logic [7:0] x);
		host.start();
		host.send({DEV, 1'b0}, acks[2]);
		host.send(r, acks[1]);
		host.send(x, acks[0]);
		host.stop();
	endtask

	// Pointer write, restart, one byte read back
	task automatic rd(input logic [7:0] r, output logic [7:0] x);
		host.start();
		host.send({DEV, 1'b0}, a);
		host.send(r, a);
		host.start();
		host.send({DEV, 1'b1}, a);
		host.recv(1'b1, x);
		host.stop();
	endtask

	task automatic wrap_up();
		$display("mismatches %0d, compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Takes the oldest note whenever a result appears
	initial forever begin
		logic [7:0] e;
		@(seen_ev);
		e = exp_q.pop_front();
		`CHK(seen, e)
	end

	// Cuts a hang short; the run needs about 26k cycles, this allows 60k
	initial begin
		#600000;
		num_errors++;
		wrap_up();
	end

	initial begin
		rstn_i = 1'b0;
		fault = 3'h0;
		in_reg = 1'b1;
		settled = 1'b1;
		seed = xs(seed);
		lvl = seed[6:0];
		choice = seed[8:7];
		idv = {MAKER, VAR, choice};
		dflt = '{8'h00, {1'b1, lvl}, 8'h2F, idv, 8'h0B};
		tick(16);
		rstn_i = 1'b1;
		tick(4);
		// Startup ramp pulse and power-up values at the ports
		note(8'h01, 8'(ramp_cnt));
		note({1'b1, lvl}, {en, level});
		note(8'h23, {1'b0, bypass, edge_spd, skip, disch, rate});
		for (int r = 0; r < 5; r++) begin
			rd(8'(r), d);
			note(dflt[r], d);
		end
		// Each fault latches, survives a zero write, clears on a one
		for (int b = 0; b < 3; b++) begin
			fault[b] = 1'b1;
			tick(3);
			fault[b] = 1'b0;
			rd(REG_FAULT, d);
			note(8'(1 << b), d);
			wr(REG_FAULT, 8'(~(1 << b)));
			rd(REG_FAULT, d);
			note(8'(1 << b), d);
			wr(REG_FAULT, 8'(1 << b));
			rd(REG_FAULT, d);
			note(8'h00, d);
		end
		// A fault still present at clear time stays latched
		fault[2] = 1'b1;
		wr(REG_FAULT, 8'h07);
		rd(REG_FAULT, d);
		note(8'h04, d);
		fault[2] = 1'b0;
		wr(REG_FAULT, 8'h07);
		// Level write waits for the stop, then disables
		seed = xs(seed);
		v = {1'b0, seed[6:0]};
		host.start();
		host.send({DEV, 1'b0}, acks[2]);
		host.send(REG_LEVEL, acks[1]);
		host.send(v, acks[0]);
		tick(20);
		note({1'b1, lvl}, {en, level});
		host.stop();
		note(8'h07, {5'h00, acks});
		note(v, {en, level});
		// Options written and read back while disabled, both polarities
		seed = xs(seed);
		for (int k = 0; k < 2; k++) begin
			v = k ? ~seed[7:0] : seed[7:0];
			wr(REG_OPTION, v);
			rd(REG_OPTION, d);
			note({3'b001, v[4:3], 2'b11, v[0]}, d);
			note({5'h00, v[4], v[3], ~v[0]}, {5'h00, bypass, edge_spd, skip});
		end
		wr(REG_IDENT, ~idv);
		rd(REG_IDENT, d);
		note(idv, d);
		// Any ramp write starts a ramp; discharge only while disabled
		v = 8'(ramp_cnt);
		wr(REG_RAMP, 8'h14);
		note(v + 8'h01, 8'(ramp_cnt));
		note(8'h01, {7'h00, disch});
		wr(REG_RAMP, 8'h34);
		note(v + 8'h02, 8'(ramp_cnt));
		rd(REG_RAMP, d);
		note(8'h3C, d);
		wr(REG_LEVEL, 8'h80);
		note(8'h00, {7'h00, disch});
		// Every rate code; reserved codes leave the field alone
		for (int c = 7; c >= 0; c--) begin
			wr(REG_RAMP, 8'(c));
			note(8'(c < 2 ? 2 : c), {5'h00, rate});
		end
		// Regulation flag, then the delayed and the bypassed pin
		wr(REG_OPTION, 8'h00);
		in_reg = 1'b0;
		tick(8);
		rd(REG_RAMP, d);
		note(8'h02, d);
		note(8'h00, {7'h00, pg});
		in_reg = 1'b1;
		tick(PG_DLY / 2);
		note(8'h00, {7'h00, pg});
		tick(PG_DLY);
		note(8'h01, {7'h00, pg});
		wr(REG_OPTION, 8'h10);
		settled = 1'b0;
		tick(8);
		note(8'h00, {7'h00, pg});
		settled = 1'b1;
		tick(8);
		note(8'h01, {7'h00, pg});
		// Foreign address and unmapped register are refused
		host.start();
		host.send({DEV_ADDR_HI, ~VAR, 1'b0}, a);
		host.stop();
		note(8'h00, {7'h00, a});
		wr(8'h05, 8'hFF);
		note(8'h02, {6'h00, acks[2:1]});
		// A slow master still reads correctly
		host.stall = 40;
		rd(REG_IDENT, d);
		note(idv, d);
		host.stall = 0;
		wrap_up();
	end
endmodule
